/* rtl/dsa_pkg.sv */
// constants shared by the data-space access unit and its region map
// How it works
// - post-increment pointer steps one for byte operations, two for word operations
// - byte read fetches whole word, address bit 0 picks byte, lands low
// - two byte lanes share word decode; byte write changes only its lane
// - word access to odd address raises address error trap, no misaligned transfer
// - misaligned read still completes before the trap is taken
// - misaligned write executes but memory write is suppressed, then trap
// - byte load into working register changes low byte, keeps high byte
// - sign extend copies bit 7 into the upper byte
// - zero extend clears the upper byte of the working register
// - near direct mode reaches 0000h to 1FFFh via 13-bit field
// - transfer instruction direct mode uses 16-bit field, whole data space
// - special function registers decode in 0000h to 07FFh
// - unimplemented addresses in the register region read as zero
// - register region implementation tracked per 32-byte region
// - low byte at even address, high byte at odd address
// - lower-half address beyond implemented memory reads all zero
// - addresses with bit 15 set go to program-space visibility window
package dsa_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int NEAR_FIELD_W = 13;
    localparam logic [15:0] SFR_TOP = 16'h07FF;
    localparam int SFR_ADDR_W = 11;
    localparam int SFR_REGION_BYTES = 32;
    localparam int SFR_REGIONS = 64;
    localparam logic [63:0] SFR_REGION_MASK = 64'h0C7700F003FFFF7F;
    localparam int RAM_BYTES_DEFAULT = 16384;
    localparam int PSV_BIT = 15;
    localparam logic [14:0] RAM_BASE_WORD = 15'h0400;
    // addressing modes of a request
    localparam logic [1:0] MODE_INDIRECT = 2'h0;
    localparam logic [1:0] MODE_NEAR = 2'h1;
    localparam logic [1:0] MODE_FULL = 2'h2;
    // working register operations
    localparam logic [1:0] WOP_NONE = 2'h0;
    localparam logic [1:0] WOP_BYTE_LOAD = 2'h1;
    localparam logic [1:0] WOP_SIGN_EXTEND = 2'h2;
    localparam logic [1:0] WOP_ZERO_EXTEND = 2'h3;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    typedef enum logic [1:0] {
        TGT_SFR = 2'b00,
        TGT_RAM = 2'b01,
        TGT_NONE = 2'b10,
        TGT_PSV = 2'b11
    } target_type;
endpackage

/* rtl/sfr_region_map.sv */
// tells whether the 32-byte register region holding an address is implemented
`timescale 1ns/1ps
`default_nettype none
module sfr_region_map #(
    parameter logic [63:0] REGION_MASK = dsa_pkg::SFR_REGION_MASK
) (
    input wire logic [10:0] sfr_addr_i,
    output logic implemented_o
);
    // 11-bit offset over 32-byte regions leaves a 6-bit region number
    assign implemented_o = REGION_MASK[sfr_addr_i[10:5]];
endmodule
`default_nettype wire

/* rtl/data_space_access_unit.sv */
// data-space access unit: address decode, byte lanes, alignment trap, extension
`timescale 1ns/1ps
`default_nettype none
module data_space_access_unit #(
    parameter int RAM_BYTES = dsa_pkg::RAM_BYTES_DEFAULT,
    parameter logic [63:0] REGION_MASK = dsa_pkg::SFR_REGION_MASK
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic req_byte_i,
    input wire logic [1:0] req_mode_i,
    input wire logic req_post_inc_i,
    input wire logic [15:0] source_pointer_register_i,
    input wire logic [15:0] req_field_i,
    input wire logic [15:0] req_wdata_i,
    output logic done_o,
    output logic rd_valid_o,
    output logic [15:0] rd_data_o,
    output logic address_error_trap_o,
    output logic [15:0] fault_address_o,
    output logic pointer_update_o,
    output logic [15:0] pointer_next_o,
    output logic sfr_sel_o,
    output logic sfr_write_o,
    output logic [1:0] sfr_lanes_o,
    output logic [10:0] sfr_addr_o,
    output logic [15:0] sfr_wdata_o,
    input wire logic [15:0] sfr_rdata_i,
    output logic psv_req_o,
    output logic [14:0] psv_addr_o,
    input wire logic [15:0] psv_rdata_i,
    input wire logic [1:0] wreg_op_i,
    input wire logic [15:0] wreg_value_i,
    input wire logic [7:0] wreg_byte_i,
    output logic wreg_valid_o,
    output logic [15:0] wreg_result_o
);
    localparam int RAM_WORDS = (RAM_BYTES - 2048) / 2;
    localparam int IDX_W = $clog2(RAM_WORDS);

    generate
        if (RAM_BYTES % 2 != 0 || RAM_BYTES <= 2048 || RAM_BYTES > 32768) begin : g_bad
            $error("RAM_BYTES must be even and lie above 2048 and at most 32768");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [1:0] lane_enables(input logic is_byte, input logic a0);
        // word writes use both lanes; a byte write only the lane its address names
        if (is_byte) begin
            lane_enables = a0 ? 2'b10 : 2'b01;
        end else begin
            lane_enables = 2'b11;
        end
    endfunction

    function automatic dsa_pkg::target_type decode(input logic [15:0] ea);
        if (ea[dsa_pkg::PSV_BIT]) begin
            decode = dsa_pkg::TGT_PSV;
        end else if (ea <= dsa_pkg::SFR_TOP) begin
            decode = dsa_pkg::TGT_SFR;
        end else if (32'(ea) < RAM_BYTES) begin
            decode = dsa_pkg::TGT_RAM;
        end else begin
            decode = dsa_pkg::TGT_NONE;
        end
    endfunction

    function automatic logic [15:0] format_read(input logic [15:0] w, input logic is_byte,
                                                input logic a0);
        if (is_byte) begin
            format_read = {8'h00, a0 ? w[15:8] : w[7:0]};
        end else begin
            format_read = w;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic s_valid;
        logic s_write;
        logic s_byte;
        logic s_lsb;
        logic s_misalign;
        dsa_pkg::target_type s_target;
        logic done;
        logic rd_valid;
        logic [15:0] rd_data;
        logic trap;
        logic [15:0] fault_addr;
        logic ptr_upd;
        logic [15:0] ptr_next;
        logic sfr_sel;
        logic sfr_write;
        logic [1:0] sfr_lanes;
        logic [10:0] sfr_addr;
        logic [15:0] sfr_wdata;
        logic psv_req;
        logic [14:0] psv_addr;
        logic wreg_valid;
        logic [15:0] wreg_result;
    } state_type;

    state_type st;
    state_type next_st;

    logic [7:0] ram_lo [RAM_WORDS];
    logic [7:0] ram_hi [RAM_WORDS];
    logic [15:0] ram_q;
    logic region_hit;

    logic [15:0] ea;
    dsa_pkg::target_type tgt;
    logic misalign;
    logic [1:0] lanes;
    logic [15:0] wdata_lanes;
    logic [IDX_W-1:0] ram_idx;
    logic ram_we_lo;
    logic ram_we_hi;
    logic [15:0] selected;

    sfr_region_map #(
        .REGION_MASK(REGION_MASK)
    ) u_region (
        .sfr_addr_i(st.sfr_addr),
        .implemented_o(region_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // request decode, same cycle as the request

    always_comb begin
        unique case (req_mode_i)
            dsa_pkg::MODE_NEAR: ea = {3'b000, req_field_i[12:0]};
            dsa_pkg::MODE_FULL: ea = req_field_i;
            default: ea = source_pointer_register_i;
        endcase
        tgt = decode(ea);
        misalign = !req_byte_i && ea[0];
        lanes = lane_enables(req_byte_i, ea[0]);
        // a byte to write arrives low and is copied onto both lanes
        wdata_lanes = req_byte_i ? {req_wdata_i[7:0], req_wdata_i[7:0]} : req_wdata_i;
        ram_idx = IDX_W'(ea[15:1] - dsa_pkg::RAM_BASE_WORD);
        // a misaligned write runs the instruction but stores nothing
        ram_we_lo = req_valid_i && req_write_i && !misalign && tgt == dsa_pkg::TGT_RAM
                    && lanes[0];
        ram_we_hi = req_valid_i && req_write_i && !misalign && tgt == dsa_pkg::TGT_RAM
                    && lanes[1];
    end

    ////////////////////////////////////////////////////////////////////////////
    // data memory: two byte-wide arrays with one word index

    always_ff @(posedge mclk_i) begin
        if (ram_we_lo) begin
            ram_lo[ram_idx] <= wdata_lanes[7:0];
        end
        if (ram_we_hi) begin
            ram_hi[ram_idx] <= wdata_lanes[15:8];
        end
        ram_q <= {ram_hi[ram_idx], ram_lo[ram_idx]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_st = st;
        // stage one: take the request
        next_st.s_valid = req_valid_i;
        next_st.s_write = req_write_i;
        next_st.s_byte = req_byte_i;
        next_st.s_lsb = ea[0];
        next_st.s_misalign = misalign;
        next_st.s_target = tgt;
        next_st.ptr_upd = req_valid_i && req_mode_i == dsa_pkg::MODE_INDIRECT && req_post_inc_i;
        next_st.ptr_next = source_pointer_register_i
                           + (req_byte_i ? dsa_pkg::STEP_BYTE : dsa_pkg::STEP_WORD);
        next_st.sfr_sel = req_valid_i && tgt == dsa_pkg::TGT_SFR
                          && !(req_write_i && misalign);
        next_st.sfr_write = req_write_i;
        next_st.sfr_lanes = lanes;
        next_st.sfr_addr = ea[10:0];
        next_st.sfr_wdata = wdata_lanes;
        next_st.psv_req = req_valid_i && tgt == dsa_pkg::TGT_PSV && !req_write_i;
        next_st.psv_addr = ea[14:0];
        // stage two: answer
        unique case (st.s_target)
            dsa_pkg::TGT_SFR: selected = region_hit ? sfr_rdata_i : 16'h0000;
            dsa_pkg::TGT_RAM: selected = ram_q;
            dsa_pkg::TGT_PSV: selected = psv_rdata_i;
            default: selected = 16'h0000;
        endcase
        next_st.done = st.s_valid;
        // the read still completes; the trap is raised in the same cycle as the answer
        next_st.rd_valid = st.s_valid && !st.s_write;
        next_st.rd_data = format_read(selected, st.s_byte, st.s_lsb);
        next_st.trap = st.s_valid && st.s_misalign;
        if (st.s_valid && st.s_misalign) begin
            next_st.fault_addr = {st.s_target == dsa_pkg::TGT_PSV, st.psv_addr};
        end
        // working register operations
        next_st.wreg_valid = wreg_op_i != dsa_pkg::WOP_NONE;
        unique case (wreg_op_i)
            dsa_pkg::WOP_BYTE_LOAD: next_st.wreg_result = {wreg_value_i[15:8],
                                                            wreg_byte_i};
            dsa_pkg::WOP_SIGN_EXTEND: next_st.wreg_result = {{8{wreg_value_i[7]}},
                                                              wreg_value_i[7:0]};
            dsa_pkg::WOP_ZERO_EXTEND: next_st.wreg_result = {8'h00, wreg_value_i[7:0]};
            default: next_st.wreg_result = st.wreg_result;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign done_o = st.done;
    assign rd_valid_o = st.rd_valid;
    assign rd_data_o = st.rd_data;
    assign address_error_trap_o = st.trap;
    assign fault_address_o = st.fault_addr;
    assign pointer_update_o = st.ptr_upd;
    assign pointer_next_o = st.ptr_next;
    assign sfr_sel_o = st.sfr_sel;
    assign sfr_write_o = st.sfr_write;
    assign sfr_lanes_o = st.sfr_lanes;
    assign sfr_addr_o = st.sfr_addr;
    assign sfr_wdata_o = st.sfr_wdata;
    assign psv_req_o = st.psv_req;
    assign psv_addr_o = st.psv_addr;
    assign wreg_valid_o = st.wreg_valid;
    assign wreg_result_o = st.wreg_result;
endmodule
`default_nettype wire

/* bench/data_space_access_unit_chk.sv */
// port-level assertions for the data-space access unit
`timescale 1ns/1ps
`default_nettype none
module data_space_access_unit_chk (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic req_byte_i,
    input wire logic [1:0] req_mode_i,
    input wire logic [15:0] source_pointer_register_i,
    input wire logic [15:0] req_field_i,
    input wire logic done_o,
    input wire logic rd_valid_o,
    input wire logic [15:0] rd_data_o,
    input wire logic address_error_trap_o,
    input wire logic pointer_update_o,
    input wire logic [15:0] pointer_next_o,
    input wire logic sfr_sel_o,
    input wire logic sfr_write_o,
    input wire logic [1:0] sfr_lanes_o,
    input wire logic [10:0] sfr_addr_o,
    input wire logic psv_req_o,
    input wire logic [14:0] psv_addr_o,
    input wire logic [1:0] wreg_op_i,
    input wire logic [15:0] wreg_value_i,
    input wire logic [7:0] wreg_byte_i,
    input wire logic wreg_valid_o,
    input wire logic [15:0] wreg_result_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_odd_word;
        req_valid_i && !req_byte_i && req_mode_i == 2'h0 && source_pointer_register_i[0];
    endsequence
    sequence s_read_req;
        req_valid_i && !req_write_i;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_post_inc_step: assert property (pointer_update_o |-> pointer_next_o ==
        $past(source_pointer_register_i) + ($past(req_byte_i) ? 16'h0001 : 16'h0002))
        else $error("pointer step wrong");
    a_read_answer: assert property (s_read_req |-> ##2 (done_o && rd_valid_o))
        else $error("read not answered in two cycles");
    a_byte_high_zero: assert property (rd_valid_o && $past(req_valid_i, 2)
        && $past(req_byte_i, 2) |-> rd_data_o[15:8] == 8'h00) else $error("byte read high lane");
    a_odd_trap: assert property (s_odd_word |-> ##2 (address_error_trap_o && done_o))
        else $error("odd word access without trap");
    a_odd_write_dropped: assert property (s_odd_word ##0 req_write_i |=> !sfr_sel_o)
        else $error("misaligned write reached registers");
    a_lane_enables: assert property (sfr_sel_o && sfr_write_o |-> sfr_lanes_o ==
        ($past(req_byte_i) ? (sfr_addr_o[0] ? 2'h2 : 2'h1) : 2'h3))
        else $error("lane enables wrong");
    a_psv_route: assert property (s_read_req ##0 req_mode_i == 2'h2
        && req_field_i[15] |=> psv_req_o && psv_addr_o == $past(req_field_i[14:0]))
        else $error("window not used");
    a_byte_load: assert property (wreg_op_i == 2'h1 |=> wreg_valid_o
        && wreg_result_o == {$past(wreg_value_i[15:8]), $past(wreg_byte_i)})
        else $error("byte load wrong");
    a_sign_extend: assert property (wreg_op_i == 2'h2 |=> wreg_valid_o
        && wreg_result_o == {{8{$past(wreg_value_i[7])}}, $past(wreg_value_i[7:0])})
        else $error("sign extend wrong");
    a_zero_extend: assert property (wreg_op_i == 2'h3 |=> wreg_valid_o
        && wreg_result_o == {8'h00, $past(wreg_value_i[7:0])}) else $error("zero extend wrong");
endmodule
bind data_space_access_unit data_space_access_unit_chk chk (.*);
`default_nettype wire

/* bench/sfr_peripheral_model.sv */
// peripheral register file answering on the register-region port
`timescale 1ns/1ps
`default_nettype none
module sfr_peripheral_model (
    input wire logic mclk_i,
    input wire logic sel_i,
    input wire logic write_i,
    input wire logic [1:0] lanes_i,
    input wire logic [10:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o
);
    logic [15:0] regs [0:1023];
    logic [15:0] last;
    // unwritten words read all ones so a zero from an empty region is the design's doing
    initial begin
        for (int i = 0; i < 1024; i++) regs[i] = 16'hFFFF;
        last = 16'h0000;
    end
    // not selected: show the inverse of the last word rather than holding it
    assign rdata_o = sel_i ? regs[addr_i[10:1]] : ~last;
    always @(posedge mclk_i) begin
        if (sel_i) begin
            last <= rdata_o;
            if (write_i && lanes_i[0]) regs[addr_i[10:1]][7:0] <= wdata_i[7:0];
            if (write_i && lanes_i[1]) regs[addr_i[10:1]][15:8] <= wdata_i[15:8];
        end
    end
endmodule
`default_nettype wire

/* bench/test_data_space_access_unit.sv */
// self-checking bench for the data-space access unit
`timescale 1ns/1ps
`default_nettype none
module test_data_space_access_unit;
    typedef struct {
        logic wr, byt, pinc, trap;
        logic [1:0] mode;
        logic [15:0] addr, wdata, exp;
    } row_type;
    logic mclk_i, rst_i, req_valid_i, req_write_i, req_byte_i, req_post_inc_i;
    logic [1:0] req_mode_i, wreg_op_i, sfr_lanes_o;
    logic [15:0] source_pointer_register_i, req_field_i, req_wdata_i, sfr_rdata_i, psv_rdata_i;
    logic [15:0] wreg_value_i, rd_data_o, fault_address_o, pointer_next_o, sfr_wdata_o;
    logic [15:0] wreg_result_o;
    logic [7:0] wreg_byte_i;
    logic done_o, rd_valid_o, address_error_trap_o, pointer_update_o, sfr_sel_o, sfr_write_o;
    logic psv_req_o, wreg_valid_o;
    logic [10:0] sfr_addr_o;
    logic [14:0] psv_addr_o;
    int num_errors = 0;
    int n_compared = 0;
    // wr byt pinc trap mode addr wdata expected-read
    row_type rows [19] = '{
        '{1'h1, 1'h0, 1'h0, 1'h0, 2'h2, 16'h0800, 16'hA55A, 16'h0000},
        '{1'h1, 1'h1, 1'h0, 1'h0, 2'h2, 16'h0801, 16'h003C, 16'h0000},
        '{1'h0, 1'h0, 1'h0, 1'h0, 2'h2, 16'h0800, 16'h0000, 16'h3C5A},
        '{1'h0, 1'h1, 1'h1, 1'h0, 2'h0, 16'h0801, 16'h0000, 16'h003C},
        '{1'h0, 1'h1, 1'h1, 1'h0, 2'h0, 16'h0800, 16'h0000, 16'h005A},
        '{1'h1, 1'h0, 1'h1, 1'h1, 2'h0, 16'h0801, 16'hFFFF, 16'h0000},
        '{1'h0, 1'h0, 1'h0, 1'h0, 2'h2, 16'h0800, 16'h0000, 16'h3C5A},
        '{1'h0, 1'h0, 1'h1, 1'h1, 2'h0, 16'h0801, 16'h0000, 16'h3C5A},
        '{1'h0, 1'h0, 1'h0, 1'h0, 2'h1, 16'hE800, 16'h0000, 16'h3C5A},
        '{1'h1, 1'h0, 1'h0, 1'h0, 2'h2, 16'h1000, 16'h1111, 16'h0000},
        '{1'h0, 1'h0, 1'h0, 1'h0, 2'h2, 16'h1000, 16'h0000, 16'h0000},
        '{1'h0, 1'h0, 1'h0, 1'h0, 2'h2, 16'h8010, 16'h0000, 16'h5A4A},
        '{1'h1, 1'h0, 1'h0, 1'h0, 2'h2, 16'h0020, 16'h1234, 16'h0000},
        '{1'h1, 1'h1, 1'h0, 1'h0, 2'h2, 16'h0021, 16'h0077, 16'h0000},
        '{1'h0, 1'h0, 1'h0, 1'h0, 2'h2, 16'h0020, 16'h0000, 16'h7734},
        // empty region reads zero though the model answers all ones
        '{1'h0, 1'h0, 1'h0, 1'h0, 2'h2, 16'h00E0, 16'h0000, 16'h0000},
        // misaligned register write must leave the word untouched
        '{1'h1, 1'h0, 1'h0, 1'h1, 2'h0, 16'h0021, 16'hFFFF, 16'h0000},
        '{1'h0, 1'h0, 1'h0, 1'h0, 2'h2, 16'h0020, 16'h0000, 16'h7734},
        // mode 3 falls back to the pointer
        '{1'h0, 1'h1, 1'h0, 1'h0, 2'h3, 16'h0800, 16'h0000, 16'h005A}
    };
    assign psv_rdata_i = {1'h0, psv_addr_o} ^ 16'h5A5A;
    data_space_access_unit #(.RAM_BYTES(4096)) dut (.*);
    sfr_peripheral_model peripheral (.mclk_i(mclk_i), .sel_i(sfr_sel_o), .write_i(sfr_write_o),
        .lanes_i(sfr_lanes_o), .addr_i(sfr_addr_o), .wdata_i(sfr_wdata_o), .rdata_o(sfr_rdata_i));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic access(input row_type r);
        req_valid_i = 1'h1;
        req_write_i = r.wr;
        req_byte_i = r.byt;
        req_mode_i = r.mode;
        req_post_inc_i = r.pinc;
        source_pointer_register_i = r.addr;
        req_field_i = r.addr;
        req_wdata_i = r.wdata;
        @(posedge mclk_i);
        #2;
        req_valid_i = 1'h0;
        check(pointer_update_o, r.pinc, "pointer update");
        if (r.pinc) check(pointer_next_o, r.addr + (r.byt ? 16'h1 : 16'h2), "step");
        @(posedge mclk_i);
        #2;
        check(done_o, 1'h1, "done");
        check(address_error_trap_o, r.trap, "trap");
        if (!r.wr) check(rd_data_o, r.exp, "read data");
        check(rd_valid_o, !r.wr, "read valid");
        if (r.trap) check(fault_address_o, r.addr, "fault address");
    endtask
    task automatic wop(input logic [1:0] op, input logic [15:0] value, input logic [15:0] exp);
        wreg_op_i = op;
        wreg_value_i = value;
        @(posedge mclk_i);
        #2;
        wreg_op_i = 2'h0;
        check(wreg_result_o, exp, "register op");
        check(wreg_valid_o, 1'h1, "register op valid");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk_i = 1'h0;
        forever #25 mclk_i = ~mclk_i;
    end
    initial begin
        #20000;
        num_errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        complete_run();
    end
    initial begin
        rst_i = 1'h1;
        {req_valid_i, req_write_i, req_byte_i, req_post_inc_i} = 4'h0;
        {req_mode_i, wreg_op_i} = 4'h0;
        {source_pointer_register_i, req_field_i, req_wdata_i, wreg_value_i} = 64'h0;
        wreg_byte_i = 8'h12;
        repeat (5) @(posedge mclk_i);
        #2;
        rst_i = 1'h0;
        foreach (rows[i]) access(rows[i]);
        $display("table of accesses done");
        // a read right behind a write to the same word must see the new data
        req_valid_i = 1'h1;
        req_write_i = 1'h1;
        req_byte_i = 1'h0;
        req_mode_i = 2'h2;
        req_field_i = 16'h0802;
        req_wdata_i = 16'hBEEF;
        @(posedge mclk_i);
        #2;
        req_write_i = 1'h0;
        @(posedge mclk_i);
        #2;
        req_valid_i = 1'h0;
        @(posedge mclk_i);
        #2;
        check(rd_data_o, 16'hBEEF, "read behind write");
        $display("back to back done");
        wop(2'h1, 16'hABCD, 16'hAB12);
        wop(2'h2, 16'h1280, 16'hFF80);
        wop(2'h3, 16'hAB95, 16'h0095);
        $display("register operations done");
        rst_i = 1'h1;
        repeat (2) @(posedge mclk_i);
        #2;
        check(rd_data_o, 16'h0000, "data after reset");
        check(fault_address_o, 16'h0000, "fault address after reset");
        rst_i = 1'h0;
        access(rows[2]);
        $display("second reset done");
        complete_run();
    end
endmodule
`default_nettype wire
